// ==== logic/rct_pkg.sv ====
package rct_pkg;

  // Clock and tick timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_BASE_PERIOD_NS = 31_250_000; // 32 Hz base tick
  localparam int TICK_BASE_CYC = TICK_BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 20;

  // Register offsets on the serial host port
  localparam logic [6:0] ADDR_MAIN_CTRL = 7'h00;
  localparam logic [6:0] ADDR_IRQ_EN = 7'h01;
  localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h02;
  localparam logic [6:0] ADDR_CNT_LOW = 7'h18;
  localparam logic [6:0] ADDR_CNT_HIGH = 7'h19;

  // Field positions
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_RELOAD_BIT = 2;
  localparam int CTRL_RATE_LO = 5;
  localparam int CTRL_RATE_HI = 6;
  localparam int IRQ_EN_TIMER_BIT = 1;
  localparam int IRQ_FLAG_TIMER_BIT = 1;
  localparam int SPI_RW_BIT = 7;

  // Reset values
  localparam logic RUN_RST = 1'b0;
  localparam logic RELOAD_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Sub-divider masks that pick every Nth base tick
  localparam logic [5:0] MASK_32HZ = 6'h00;
  localparam logic [5:0] MASK_8HZ = 6'h03;
  localparam logic [5:0] MASK_1HZ = 6'h1F;
  localparam logic [5:0] MASK_HALF_HZ = 6'h3F;

  // Tick source choices, in field encoding order
  typedef enum logic [1:0] {
    RATE_32HZ,
    RATE_8HZ,
    RATE_1HZ,
    RATE_HALF_HZ
  } rct_rate_e;

  localparam rct_rate_e RATE_RST = RATE_32HZ;

  // Serial frame phase
  typedef enum logic {
    SPI_CMD,
    SPI_DATA
  } rct_phase_e;

  // One register write from the host port
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } rct_wr_s;

endpackage

// ==== logic/rct_tick_gen.sv ====
`timescale 1ns/10ps
module rct_tick_gen
  import rct_pkg::*;
#(
  parameter int BASE_CYCLES = TICK_BASE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Rate choice and tick out
  input rct_rate_e rate,
  output logic tick
);

  logic [TICK_CNT_W-1:0] baseFF;
  logic [5:0] subFF;
  logic [5:0] mask;
  logic baseWrap;
  logic [5:0] wrapsFF;
  logic halfRunFF;

  // Mask picks 1 of 1, 4, 32 or 64 base ticks
  function automatic logic [5:0] rateMask(input rct_rate_e r);
    case (r)
      RATE_32HZ: rateMask = MASK_32HZ;
      RATE_8HZ: rateMask = MASK_8HZ;
      RATE_1HZ: rateMask = MASK_1HZ;
      RATE_HALF_HZ: rateMask = MASK_HALF_HZ;
      default: rateMask = MASK_32HZ;
    endcase
  endfunction

  // Free-running chain; rate change may shorten the first tick
  assign baseWrap = baseFF == TICK_CNT_W'(BASE_CYCLES - 1);
  assign mask = rateMask(rate);
  assign tick = baseWrap && ((subFF & mask) == mask);

  // Base and sub dividers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      baseFF <= '0;
      subFF <= '0;
    end else begin
      baseFF <= baseWrap ? '0 : baseFF + 1'b1;
      subFF <= baseWrap ? subFF + 6'h01 : subFF;
    end
  end

  // Base wraps since the last tick; the period is only known once a half-hertz
  // tick has aligned the sub-divider, so earlier rates are not judged
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrapsFF <= 6'h00;
      halfRunFF <= 1'b0;
    end else if (tick) begin
      wrapsFF <= 6'h00;
      halfRunFF <= (rate == RATE_HALF_HZ);
    end else begin
      wrapsFF <= baseWrap ? wrapsFF + 6'h01 : wrapsFF;
      halfRunFF <= halfRunFF && (rate == RATE_HALF_HZ);
    end
  end

  // A steady half-hertz tick comes every 64 base periods: 63 wraps in between
  property p_rate_slow_tick;
    @(posedge core_clk) disable iff (!rst_n)
      (tick && rate == RATE_HALF_HZ && halfRunFF) |-> wrapsFF == 6'h3F;
  endproperty
  a_rate_slow_tick: assert property (p_rate_slow_tick)
    else $error("half-hertz tick out of phase");

endmodule

// ==== logic/rct_spi_port.sv ====
`timescale 1ns/10ps
module rct_spi_port
  import rct_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMisoOut,
  output logic spiMisoOeN,
  // Register side
  input wire logic [7:0] rdData,
  output logic [6:0] rdAddr,
  output rct_wr_s wr
);

  logic [2:0] sclkPipeFF;
  logic [1:0] csPipeFF;
  logic [1:0] mosiPipeFF;
  rct_phase_e phaseFF;
  logic [2:0] bitCntFF;
  logic [7:0] rxFF;
  logic [7:0] txFF;
  logic rwFF;
  logic loadFF;
  logic [6:0] addrFF;
  rct_wr_s wrFF;
  logic rise;
  logic fall;
  logic selected;
  logic byteEnd;
  logic [7:0] rxByte;

  // Select and data pins pass two flops, serial clock three; stage 0 feeds stage 1 only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclkPipeFF <= 3'h0;
      csPipeFF <= 2'h3;
      mosiPipeFF <= 2'h0;
    end else begin
      sclkPipeFF <= {sclkPipeFF[1:0], spiSclk};
      csPipeFF <= {csPipeFF[0], spiCsN};
      mosiPipeFF <= {mosiPipeFF[0], spiMosi};
    end
  end

  // Mode 0: sample on rising, shift out on falling
  assign rise = sclkPipeFF[1] && !sclkPipeFF[2];
  assign fall = !sclkPipeFF[1] && sclkPipeFF[2];
  assign selected = !csPipeFF[1];
  assign rxByte = {rxFF[6:0], mosiPipeFF[1]};
  assign byteEnd = selected && rise && bitCntFF == 3'h7;
  assign rdAddr = addrFF;
  assign wr = wrFF;
  assign spiMisoOut = txFF[7];
  assign spiMisoOeN = !selected;

  // Framing: command byte, then data bytes with address increment
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phaseFF <= SPI_CMD;
      bitCntFF <= 3'h0;
      rxFF <= 8'h00;
      rwFF <= 1'b0;
      addrFF <= 7'h00;
      wrFF <= '0;
    end else begin
      wrFF.en <= 1'b0;
      if (!selected) begin
        phaseFF <= SPI_CMD;
        bitCntFF <= 3'h0;
      end else if (rise) begin
        rxFF <= rxByte;
        bitCntFF <= bitCntFF + 3'h1;
      end
      if (byteEnd && phaseFF == SPI_CMD) begin
        addrFF <= rxByte[6:0];
        rwFF <= rxByte[SPI_RW_BIT];
        phaseFF <= SPI_DATA;
      end else if (byteEnd) begin
        wrFF <= '{en: !rwFF, addr: addrFF, data: rxByte};
        addrFF <= addrFF + 7'h01;
      end
    end
  end

  // Reply byte loads on the falling edge after each byte ends
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txFF <= 8'h00;
      loadFF <= 1'b0;
    end else if (byteEnd) begin
      loadFF <= 1'b1;
    end else if (selected && fall) begin
      txFF <= loadFF ? rdData : {txFF[6:0], 1'b0};
      loadFF <= 1'b0;
    end
  end

  property p_write_single;
    @(posedge core_clk) disable iff (!rst_n)
      wrFF.en |=> !wrFF.en;
  endproperty
  a_write_single: assert property (p_write_single)
    else $error("write pulse longer than one cycle");

endmodule

// ==== logic/rct_countdown_timer.sv ====
`timescale 1ns/10ps
// Behaviour
// - Countdown runs only while run-enable (bit 1 at 00h) is set.
// - Rate field bits 6:5 selects 32 Hz, 8 Hz, 1 Hz or 0.5 Hz ticks.
// - Start value is 16 bits, low byte at 18h, high byte at 19h.
// - Start values 1 upward are valid; zero keeps the timer still.
// - A period ends when the count reaches zero.
// - With auto-reload set, start value reloads and next period begins.
// - Reload costs one tick: first period n ticks, later ones n+1.
// - With timer interrupt enabled, period end sets the timer flag.
// - Interrupt follows the flag while timer interrupt is enabled; the flag stays until software writes 0.
// - Rate and auto-reload writes accepted only while run-enable is 0.
// - Count writes accepted only with run-enable and auto-reload both 0.
// - Interrupt pin is active low and open drain.
// - Reset leaves timer and reload off, tick source at 32 Hz.
// - Writing 0 to the flag releases the interrupt, unless a period ends in that same cycle.
module rct_countdown_timer
  import rct_pkg::*;
#(
  parameter int TICK_BASE_CYCLES = TICK_BASE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial host port
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMisoOut,
  output logic spiMisoOeN,
  // Open-drain interrupt pin
  input wire logic intPinIn,
  output logic intPinOut,
  output logic intPinOeN
);

  rct_wr_s wr;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  logic tick;

  logic runEnFF;
  logic autoReloadFF;
  rct_rate_e rateFF;
  logic irqEnFF;
  logic doneFlagFF;
  logic [15:0] startFF;
  logic [15:0] cntFF;

  logic nxt_runEn;
  logic nxt_autoReload;
  rct_rate_e nxt_rate;
  logic nxt_irqEn;
  logic nxt_doneFlag;
  logic [15:0] nxt_start;
  logic [15:0] nxt_cnt;

  logic wrMain;
  logic wrIrqEn;
  logic wrFlags;
  logic wrLow;
  logic wrHigh;
  logic cfgOpen;
  logic cntOpen;
  logic tickNow;
  logic reachZero;
  logic reloadNow;
  logic flagClear;
  logic irqActive;
  logic [7:0] ctrlRd;
  logic [7:0] irqEnRd;
  logic [7:0] flagRd;

  // A write that lands on one register address
  function automatic logic hitAddr(input rct_wr_s w, input logic [6:0] a);
    hitAddr = w.en && (w.addr == a);
  endfunction

  // Host port: frames in, register writes and read data out
  rct_spi_port u_spi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .spiSclk(spiSclk),
    .spiCsN(spiCsN),
    .spiMosi(spiMosi),
    .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN),
    .rdData(rdData),
    .rdAddr(rdAddr),
    .wr(wr)
  );

  // Tick source from the internal divider chain
  rct_tick_gen #(
    .BASE_CYCLES(TICK_BASE_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rate(rateFF),
    .tick(tick)
  );

  // Write decode
  assign wrMain = hitAddr(wr, ADDR_MAIN_CTRL);
  assign wrIrqEn = hitAddr(wr, ADDR_IRQ_EN);
  assign wrFlags = hitAddr(wr, ADDR_IRQ_FLAGS);
  assign wrLow = hitAddr(wr, ADDR_CNT_LOW);
  assign wrHigh = hitAddr(wr, ADDR_CNT_HIGH);

  // Write locks judge the state before this write, not after
  assign cfgOpen = !runEnFF;
  assign cntOpen = !runEnFF && !autoReloadFF;

  // Countdown events
  assign tickNow = tick && runEnFF;
  assign reachZero = tickNow && cntFF == 16'h0001;
  // Reload spends a whole tick at zero, so later periods run n+1
  assign reloadNow = tickNow && autoReloadFF && cntFF == 16'h0000 &&
                     startFF != 16'h0000;
  // Only a written 0 clears; a written 1 is ignored
  assign flagClear = wrFlags && !wr.data[IRQ_FLAG_TIMER_BIT];

  // Pin is pulled low while active, released otherwise
  assign irqActive = doneFlagFF && irqEnFF;
  assign intPinOut = 1'b0;
  assign intPinOeN = !irqActive;

  // Control register next values
  always_comb begin
    nxt_runEn = runEnFF;
    nxt_autoReload = autoReloadFF;
    nxt_rate = rateFF;
    if (wrMain) begin
      nxt_runEn = wr.data[CTRL_RUN_BIT];
    end
    if (wrMain && cfgOpen) begin
      nxt_autoReload = wr.data[CTRL_RELOAD_BIT];
      nxt_rate = rct_rate_e'(wr.data[CTRL_RATE_HI:CTRL_RATE_LO]);
    end
  end

  // Interrupt enable and flag; a period end beats a same-cycle clear
  always_comb begin
    nxt_irqEn = wrIrqEn ? wr.data[IRQ_EN_TIMER_BIT] : irqEnFF;
    nxt_doneFlag = (doneFlagFF && !flagClear) ||
                   (reachZero && irqEnFF);
  end

  // Start value and live count
  always_comb begin
    nxt_start = startFF;
    nxt_cnt = cntFF;
    if (wrLow && cntOpen) begin
      nxt_start = {startFF[15:8], wr.data};
      nxt_cnt = {cntFF[15:8], wr.data};
    end else if (wrHigh && cntOpen) begin
      nxt_start = {wr.data, startFF[7:0]};
      nxt_cnt = {wr.data, cntFF[7:0]};
    end else if (reloadNow) begin
      nxt_cnt = startFF;
    end else if (tickNow && cntFF != 16'h0000) begin
      nxt_cnt = cntFF - 16'h0001;
    end
  end

  // Control registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      runEnFF <= RUN_RST;
      autoReloadFF <= RELOAD_RST;
      rateFF <= RATE_RST;
      irqEnFF <= IRQ_EN_RST;
      doneFlagFF <= FLAG_RST;
    end else begin
      runEnFF <= nxt_runEn;
      autoReloadFF <= nxt_autoReload;
      rateFF <= nxt_rate;
      irqEnFF <= nxt_irqEn;
      doneFlagFF <= nxt_doneFlag;
    end
  end

  // Count registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      startFF <= CNT_RST;
      cntFF <= CNT_RST;
    end else begin
      startFF <= nxt_start;
      cntFF <= nxt_cnt;
    end
  end

  // Read images; unused bits read as zero
  always_comb begin
    ctrlRd = READ_IDLE;
    ctrlRd[CTRL_RUN_BIT] = runEnFF;
    ctrlRd[CTRL_RELOAD_BIT] = autoReloadFF;
    ctrlRd[CTRL_RATE_HI:CTRL_RATE_LO] = rateFF;
    irqEnRd = READ_IDLE;
    irqEnRd[IRQ_EN_TIMER_BIT] = irqEnFF;
    flagRd = READ_IDLE;
    flagRd[IRQ_FLAG_TIMER_BIT] = doneFlagFF;
  end

  // Read mux; count addresses show the live count
  always_comb begin
    case (rdAddr)
      ADDR_MAIN_CTRL: rdData = ctrlRd;
      ADDR_IRQ_EN: rdData = irqEnRd;
      ADDR_IRQ_FLAGS: rdData = flagRd;
      ADDR_CNT_LOW: rdData = cntFF[7:0];
      ADDR_CNT_HIGH: rdData = cntFF[15:8];
      default: rdData = READ_IDLE;
    endcase
  end

  property p_stopped_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (!runEnFF && !wrLow && !wrHigh) |=> $stable(cntFF);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("count moved while stopped");

  property p_tick_decrements;
    @(posedge core_clk) disable iff (!rst_n)
      (tick && runEnFF && cntFF != 16'h0000 && !wr.en) |=>
        cntFF == $past(cntFF) - 16'h0001;
  endproperty
  a_tick_decrements: assert property (p_tick_decrements)
    else $error("count did not drop by one on a tick");

  property p_flag_on_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (tick && runEnFF && irqEnFF && cntFF == 16'h0001) |=>
        doneFlagFF ##0 !intPinOeN;
  endproperty
  a_flag_on_zero: assert property (p_flag_on_zero)
    else $error("timer flag not set at period end");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      (doneFlagFF && !flagClear) |=> doneFlagFF;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("timer flag dropped without a clear");

  property p_clear_releases;
    @(posedge core_clk) disable iff (!rst_n)
      (flagClear && !reachZero) |=> intPinOeN && !doneFlagFF;
  endproperty
  a_clear_releases: assert property (p_clear_releases)
    else $error("interrupt not released after clear");

  property p_cfg_locked;
    @(posedge core_clk) disable iff (!rst_n)
      (wrMain && runEnFF) |=> $stable(rateFF) && $stable(autoReloadFF);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("rate or reload changed while running");

  property p_count_locked;
    @(posedge core_clk) disable iff (!rst_n)
      ((wrLow || wrHigh) && (runEnFF || autoReloadFF)) |=> $stable(startFF);
  endproperty
  a_count_locked: assert property (p_count_locked)
    else $error("start value written while locked");

  property p_reload_extra_tick;
    @(posedge core_clk) disable iff (!rst_n)
      (tick && runEnFF && autoReloadFF && cntFF == 16'h0000 &&
       startFF != 16'h0000 && !wr.en) |=> cntFF == $past(startFF);
  endproperty
  a_reload_extra_tick: assert property (p_reload_extra_tick)
    else $error("reload did not restore the start value");

  property p_hold_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (!autoReloadFF && cntFF == 16'h0000 && !wrLow && !wrHigh) |=>
        cntFF == 16'h0000;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("count left zero without a load");

  property p_reset_state;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> !runEnFF && !autoReloadFF && rateFF == RATE_32HZ;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong control state after reset");

endmodule

// ==== test/rct_spi_host.sv ====
`timescale 1ns/10ps
// Host end of the serial port: mode 0, each clock phase lasts six core cycles
module rct_spi_host (
  // Clock
  input wire logic core_clk,
  // Serial pins toward the device
  input wire logic misoLine,
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi
);
  // Serial clock parks low outside frames and the select starts released
  initial begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // One frame: command byte, then one data byte, MSB first, reply taken at each rise of the data byte
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] bits;
    bits = {rw, addr, wdat};
    rdat = 8'h00;
    @(negedge core_clk);
    spiCsN = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      spiSclk = 1'b0;
      spiMosi = bits[i];
      repeat (6) @(negedge core_clk);
      spiSclk = 1'b1;
      if (i < 8) begin
        rdat[i] = misoLine;
      end
      repeat (6) @(negedge core_clk);
    end
    spiSclk = 1'b0;
    // Data line does not keep its last value once the frame is over
    spiMosi = ~spiMosi;
    repeat (4) @(negedge core_clk);
    spiCsN = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// ==== test/test_rct_countdown_timer.sv ====
`timescale 1ns/10ps
module test_rct_countdown_timer;
  import rct_pkg::*;
  // Short base tick so that every rate fits a brief run
  localparam int TBC = 8;
  typedef struct {rct_rate_e rate; logic [15:0] n; int period;} rct_row_s;
  logic core_clk, rst_n, spiSclk, spiCsN, spiMosi, spiMisoOut, spiMisoOeN;
  logic intPinOut, intPinOeN, misoLine, intLine;
  logic flip = 1'b0;
  logic prevOe = 1'b1;
  int cyc = 0;
  int fallCyc = 0;
  int n_fail = 0;
  int checks_done = 0;
  int t0, t1;
  rct_row_s r;
  // Reload periods are n+1 ticks, long enough to clear the flag in between
  rct_row_s rows [4] = '{'{RATE_32HZ, 16'h0063, 100 * TBC}, '{RATE_8HZ, 16'h0018, 100 * TBC},
                         '{RATE_1HZ, 16'h0002, 96 * TBC}, '{RATE_HALF_HZ, 16'h0001, 128 * TBC}};

  // Undriven MISO toggles, so a stale bit can never pass; interrupt line is pulled up
  assign misoLine = spiMisoOeN ? flip : spiMisoOut;
  assign intLine = intPinOeN ? 1'b1 : intPinOut;

  rct_countdown_timer #(.TICK_BASE_CYCLES(TBC)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut),
    .spiMisoOeN(spiMisoOeN), .intPinIn(intLine), .intPinOut(intPinOut),
    .intPinOeN(intPinOeN));

  rct_spi_host hostU (.core_clk(core_clk), .misoLine(misoLine), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cycle count and the cycle of each fresh interrupt assertion
  always @(posedge core_clk) begin
    flip <= ~flip;
    cyc <= cyc + 1;
    if (prevOe === 1'b1 && intPinOeN === 1'b0) begin
      fallCyc <= cyc;
    end
    prevOe <= intPinOeN;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    hostU.xfer(1'b0, a, d, unused);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] g;
    hostU.xfer(1'b1, a, 8'h00, g);
    chk({8'h00, g}, {8'h00, e});
  endtask

  // Bounded wait for the next interrupt assertion after the one seen at cycle last
  task automatic waitFall(input int last, input int bound);
    int k;
    k = 0;
    while (fallCyc == last && k < bound) begin
      @(posedge core_clk);
      k++;
    end
    if (fallCyc == last) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, k, bound);
      complete_run();
    end
  endtask

  task automatic doReset();
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    doReset();
    chk(intPinOeN, 1'b1);
    rd(ADDR_MAIN_CTRL, 8'h00);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    rd(7'h05, 8'h00);
    wr(ADDR_IRQ_EN, 8'h02);
    // Every rate with auto-reload: second period must be exactly n+1 ticks
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      wr(ADDR_MAIN_CTRL, 8'h00);
      wr(ADDR_MAIN_CTRL, 8'h00);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_CNT_LOW, r.n[7:0]);
      wr(ADDR_CNT_HIGH, r.n[15:8]);
      rd(ADDR_CNT_LOW, r.n[7:0]);
      rd(ADDR_CNT_HIGH, r.n[15:8]);
      t0 = fallCyc;
      wr(ADDR_MAIN_CTRL, {1'b0, r.rate, 5'h06});
      waitFall(t0, r.period + 600);
      t1 = fallCyc;
      chk(intPinOut, 1'b0);
      rd(ADDR_IRQ_FLAGS, 8'h02);
      chk(intPinOeN, 1'b0);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      chk(intPinOeN, 1'b1);
      waitFall(t1, r.period + 100);
      chk(16'(fallCyc - t1), 16'(r.period));
    end
    // Write locks, then a run without reload that must stop at zero
    wr(ADDR_MAIN_CTRL, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h00);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_CNT_LOW, 8'h05);
    wr(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h04);
    wr(ADDR_CNT_LOW, 8'hAA);
    rd(ADDR_CNT_LOW, 8'h05);
    wr(ADDR_MAIN_CTRL, 8'h02);
    wr(ADDR_MAIN_CTRL, 8'h66);
    rd(ADDR_MAIN_CTRL, 8'h02);
    wr(ADDR_CNT_LOW, 8'hAA);
    rd(ADDR_CNT_LOW, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h02);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    repeat (200) @(negedge core_clk);
    chk(intPinOeN, 1'b1);
    // Stopped timer keeps its count
    wr(ADDR_MAIN_CTRL, 8'h00);
    wr(ADDR_CNT_LOW, 8'h03);
    repeat (300) @(negedge core_clk);
    rd(ADDR_CNT_LOW, 8'h03);
    // Zero start value never ends a period, even with reload
    wr(ADDR_CNT_LOW, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h06);
    repeat (300) @(negedge core_clk);
    chk(intPinOeN, 1'b1);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    // Second reset while running
    doReset();
    rd(ADDR_MAIN_CTRL, 8'h00);
    rd(ADDR_IRQ_EN, 8'h00);
    chk(intPinOeN, 1'b1);
    // Timer interrupt disabled: period end leaves the flag clear
    wr(ADDR_CNT_LOW, 8'h03);
    wr(ADDR_MAIN_CTRL, 8'h02);
    repeat (300) @(negedge core_clk);
    rd(ADDR_CNT_LOW, 8'h00);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    chk(intPinOeN, 1'b1);
    complete_run();
  end
endmodule
